/* include/csoir_pkg.sv */
// Package: register map, field positions and reset values of the core regs
package csoir_pkg;
    // Register addresses within the 9-bit data space
    localparam logic [8:0] ADDR_ALU_FLAGS_BANK_SELECT   = 9'h003;
    localparam logic [8:0] ADDR_INTERRUPT_CONTROL_CORE  = 9'h00B;
    localparam logic [8:0] ADDR_PERIPHERAL_IRQ_FLAGS    = 9'h00C;
    localparam logic [8:0] ADDR_TIMER_PRESCALER_CONFIG  = 9'h081;
    localparam logic [8:0] ADDR_PERIPHERAL_IRQ_ENABLE   = 9'h08C;
    // Mask that folds mirrored banks onto one offset
    localparam logic [8:0] ADDR_ANY_BANK_MASK           = 9'h07F;
    localparam logic [8:0] ADDR_OPTION_BANK_MASK        = 9'h0FF;

    // Status register fields
    localparam int ST_INDIRECT_BANK = 7;
    localparam int ST_DIRECT_HI     = 6;
    localparam int ST_DIRECT_LO     = 5;
    localparam int ST_WDOG_EXPIRY   = 4;
    localparam int ST_SLEEP_ENTERED = 3;
    localparam int ST_RESULT_NULL   = 2;
    localparam int ST_HALF_CARRY    = 1;
    localparam int ST_CARRY         = 0;

    // Timer/prescaler configuration fields
    localparam int OPT_PULLUP_DIS   = 7;
    localparam int OPT_EXT_EDGE     = 6;
    localparam int OPT_T0_SOURCE    = 5;
    localparam int OPT_T0_EDGE      = 4;
    localparam int OPT_PSC_OWNER    = 3;
    localparam int OPT_RATIO_HI     = 2;
    localparam int OPT_RATIO_LO     = 0;

    // Interrupt control fields
    localparam int IC_GLOBAL_EN     = 7;
    localparam int IC_PERIPH_EN     = 6;
    localparam int IC_T0_EN         = 5;
    localparam int IC_EXT_EN        = 4;
    localparam int IC_PORT_EN       = 3;
    localparam int IC_T0_FLAG       = 2;
    localparam int IC_EXT_FLAG      = 1;
    localparam int IC_PORT_FLAG     = 0;

    // Implemented peripheral enable / flag bits
    localparam logic [7:0] PERIPH_IMPL_MASK = 8'h4F;

    // Reset values
    localparam logic [7:0] ST_RESET       = 8'h18;
    localparam logic [7:0] OPT_RESET      = 8'hFF;
    localparam logic [7:0] IC_RESET       = 8'h00;
    localparam logic [7:0] PIE_RESET      = 8'h00;

    // Flag update source from the ALU
    typedef enum logic [1:0] {
        CSOIR_CARRY_NONE,
        CSOIR_CARRY_ARITH,
        CSOIR_CARRY_ROT_LEFT,
        CSOIR_CARRY_ROT_RIGHT
    } csoir_carry_src_type;
endpackage : csoir_pkg

/* verilog/csoir_edge_detect.sv */
// Edge detector for the external interrupt pin with selectable polarity
`timescale 1ns/1ns
module csoir_edge_detect (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Pin and selection
    input  wire logic pinLevel,    // Synchronous pin input
    input  wire logic risingSel,   // 1 rising, 0 falling
    // Event
    output logic      edgeSeen     // One-cycle pulse on selected edge
);
    logic prevLevel_q;             // Last sampled pin level

    // Remember previous level
    always_ff @(posedge clock) begin
        if (rst) begin
            // Track the pin so no false edge follows reset
            prevLevel_q <= pinLevel;
        end else begin
            prevLevel_q <= pinLevel;
        end
    end

    // Select the edge by polarity
    always_comb begin
        if (risingSel) begin
            edgeSeen = pinLevel & ~prevLevel_q;
        end else begin
            edgeSeen = ~pinLevel & prevLevel_q;
        end
    end
endmodule : csoir_edge_detect

/* verilog/csoir_port_change.sv */
// Mismatch detector for the upper four port B pins
`timescale 1ns/1ns
module csoir_port_change #(
    parameter int WIDTH = 4        // Number of watched pins
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Pins and port read
    input  wire logic [WIDTH-1:0] pins,      // Upper port B levels
    input  wire logic             portRead,  // Port B read: relatch
    // Mismatch level
    output logic                  mismatch   // Pins differ from latch
);
    logic [WIDTH-1:0] latched_q;   // Levels seen at last port read

    // Latch levels at each port read, ending the mismatch
    always_ff @(posedge clock) begin
        if (rst) begin
            latched_q <= pins; // No false change after reset
        end else if (portRead) begin
            latched_q <= pins;
        end
    end

    // Any difference is a pending change
    assign mismatch = |(pins ^ latched_q);
endmodule : csoir_port_change

/* verilog/csoir_core_regs.sv */
// Core status, prescaler option and interrupt control register group
//
// Functional notes
// - Flag-updating writes to status keep ALU flags
// - Watchdog-expiry and sleep flags are software read-only
// - Bit 7 picks indirect upper or lower banks
// - Bits 6-5 pick one of four direct banks
// - Expiry flag set at reset/clear/sleep, cleared timeout
// - Sleep flag set reset/clear-watchdog, cleared by sleep
// - Result-null flag follows zero result
// - Half-carry records low nibble carry out
// - Carry records MSB carry, borrow inverted
// - Rotate loads carry with shifted-out bit
// - Pull-up disable bit forces all pull-ups off
// - Edge bit picks external pin rising or falling
// - Source bit picks external pin or instruction clock
// - Edge bit picks falling or rising timer clock
// - Owner bit gives prescaler to watchdog or timer
// - Ratio divides timer 2^(n+1), watchdog 2^n
// - Flags set regardless of any enable
// - Global enable permits or suppresses all interrupts
// - Peripheral group enable and per-source mask bits
// - Timer overflow flag bit 2, enable bit 5
// - External pin flag bit 1, enable bit 4
// - Port-change flag held while mismatch persists
// - Peripheral flags live in separate register
`timescale 1ns/1ns
module csoir_core_regs #(
    parameter int PORT_WIDTH = 4   // Watched upper port B pins
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Instruction register access
    input  wire logic [8:0]            regAddr,     // Effective address
    input  wire logic                  regWrite,    // Write strobe
    input  wire logic [7:0]            regWdata,    // Write data
    output logic      [7:0]            regRdata,    // Read data, registered
    // ALU flag update strobes
    input  wire logic                  nullUpdate,  // Instr affects null
    input  wire logic                  halfUpdate,  // Instr affects half
    input  wire logic                  carryUpdate, // Instr affects carry
    input  wire csoir_pkg::csoir_carry_src_type carrySrc, // Carry source
    input  wire logic [7:0]            aluResult,   // ALU result byte
    input  wire logic                  nibbleCarry, // Carry out of bit 3
    input  wire logic                  msbCarry,    // Carry out of bit 7
    input  wire logic [7:0]            rotSource,   // Rotate source byte
    // Core events
    input  wire logic                  clearWatchdogInstr, // Clear wdog
    input  wire logic                  sleepInstr,  // Sleep executed
    input  wire logic                  watchdogTimeout, // Wdog expired
    input  wire logic                  timerZeroOverflow, // Timer0 wrap
    input  wire logic                  extIrqPin,   // External irq pin
    input  wire logic [PORT_WIDTH-1:0] upperPortBPins, // Watched pins
    input  wire logic                  portBRead,   // Port B was read
    input  wire logic [7:0]            peripheralIrqFlags, // Flag reg
    // Configuration outputs
    output logic                       indirectBankSel, // Upper half
    output logic      [1:0]            directBankSel,   // Direct bank
    output logic                       pullupDisable,   // All pull-ups off
    output logic                       timer0SourceSel, // External clock
    output logic                       timer0EdgeSel,   // Falling edge
    output logic                       timerPrescaled,  // Psc on timer0
    output logic                       watchdogPrescaled, // Psc on wdog
    output logic      [7:0]            timerDivMinus1,  // Timer div - 1
    output logic      [7:0]            watchdogDivMinus1, // Wdog div - 1
    // Interrupt request
    output logic                       irqRequest   // Core interrupt
);
    logic [7:0] status_q;          // Status register
    logic [7:0] option_q;          // Prescaler configuration
    logic [7:0] intCtl_q;          // Interrupt control
    logic [7:0] perEn_q;           // Peripheral enables
    logic [7:0] regRdata_q;        // Read data register
    logic       irq_q;             // Request register
    logic [7:0] dividers_q [2];    // Timer and watchdog divide - 1
    logic       extEdge;           // Selected external edge pulse
    logic       portMismatch;      // Port B mismatch level
    logic       writeStatus;       // Status write decode
    logic       writeOption;       // Option write decode
    logic       writeIntCtl;       // Interrupt control write decode
    logic       writePerEn;        // Peripheral enable write decode
    logic       irq_d;             // Next request

    // Fold bank mirrors; status and control appear in every bank
    function automatic logic hits(input logic [8:0] a,
                                  input logic [8:0] reg_addr,
                                  input logic [8:0] mask);
        hits = (a & mask) == reg_addr;
    endfunction : hits

    // Divide minus one for a power of two exponent
    function automatic logic [7:0] pow2m1(input logic [3:0] n);
        pow2m1 = 8'(({8'h00, 8'h01} << n) - 16'h0001);
    endfunction : pow2m1

    // Edge detect on the external interrupt pin
    csoir_edge_detect u_edge (
        .clock     (clock),
        .rst       (rst),
        .pinLevel  (extIrqPin),
        .risingSel (option_q[csoir_pkg::OPT_EXT_EDGE]),
        .edgeSeen  (extEdge)
    );

    // Mismatch detector on the watched pins
    csoir_port_change #(
        .WIDTH (PORT_WIDTH)
    ) u_port (
        .clock    (clock),
        .rst      (rst),
        .pins     (upperPortBPins),
        .portRead (portBRead),
        .mismatch (portMismatch)
    );

    // Address decode
    assign writeStatus = regWrite & hits(regAddr,
        csoir_pkg::ADDR_ALU_FLAGS_BANK_SELECT, csoir_pkg::ADDR_ANY_BANK_MASK);
    assign writeIntCtl = regWrite & hits(regAddr,
        csoir_pkg::ADDR_INTERRUPT_CONTROL_CORE,
        csoir_pkg::ADDR_ANY_BANK_MASK);
    assign writeOption = regWrite & hits(regAddr,
        csoir_pkg::ADDR_TIMER_PRESCALER_CONFIG,
        csoir_pkg::ADDR_OPTION_BANK_MASK);
    assign writePerEn  = regWrite &
        (regAddr == csoir_pkg::ADDR_PERIPHERAL_IRQ_ENABLE);

    // Bank selects, written by software only
    always_ff @(posedge clock) begin
        if (rst) begin
            status_q[7:5] <= csoir_pkg::ST_RESET[7:5];
        end else if (writeStatus) begin
            status_q[7:5] <= regWdata[7:5];
        end
    end

    // Reset-cause flags: hardware events only
    always_ff @(posedge clock) begin
        if (rst) begin
            status_q[4:3] <= csoir_pkg::ST_RESET[4:3];
        end else if (sleepInstr) begin
            status_q[csoir_pkg::ST_WDOG_EXPIRY]   <= 1'b1;
            status_q[csoir_pkg::ST_SLEEP_ENTERED] <= 1'b0;
        end else if (clearWatchdogInstr) begin
            status_q[csoir_pkg::ST_WDOG_EXPIRY]   <= 1'b1;
            status_q[csoir_pkg::ST_SLEEP_ENTERED] <= 1'b1;
        end else if (watchdogTimeout) begin
            status_q[csoir_pkg::ST_WDOG_EXPIRY]   <= 1'b0;
        end
        // Software writes never reach these bits
    end

    // Result-null flag
    always_ff @(posedge clock) begin
        if (rst) begin
            status_q[csoir_pkg::ST_RESULT_NULL] <= 1'b0;
        end else if (nullUpdate) begin
            status_q[csoir_pkg::ST_RESULT_NULL] <=
                aluResult == 8'h00;
        end else if (writeStatus) begin
            status_q[csoir_pkg::ST_RESULT_NULL] <=
                regWdata[csoir_pkg::ST_RESULT_NULL];
        end
    end

    // Half-carry flag
    always_ff @(posedge clock) begin
        if (rst) begin
            status_q[csoir_pkg::ST_HALF_CARRY] <= 1'b0;
        end else if (halfUpdate) begin
            status_q[csoir_pkg::ST_HALF_CARRY] <= nibbleCarry;
        end else if (writeStatus) begin
            status_q[csoir_pkg::ST_HALF_CARRY] <=
                regWdata[csoir_pkg::ST_HALF_CARRY];
        end
    end

    // Carry flag, including rotates through carry
    always_ff @(posedge clock) begin
        if (rst) begin
            status_q[csoir_pkg::ST_CARRY] <= 1'b0;
        end else if (carryUpdate) begin
            case (carrySrc)
                csoir_pkg::CSOIR_CARRY_ROT_LEFT: begin
                    status_q[csoir_pkg::ST_CARRY] <= rotSource[7];
                end
                csoir_pkg::CSOIR_CARRY_ROT_RIGHT: begin
                    status_q[csoir_pkg::ST_CARRY] <= rotSource[0];
                end
                default: begin
                    // Subtract adds two's complement: 1 means no borrow
                    status_q[csoir_pkg::ST_CARRY] <= msbCarry;
                end
            endcase
        end else if (writeStatus) begin
            status_q[csoir_pkg::ST_CARRY] <= regWdata[csoir_pkg::ST_CARRY];
        end
    end

    // Prescaler and pin configuration
    always_ff @(posedge clock) begin
        if (rst) begin
            option_q <= csoir_pkg::OPT_RESET;
        end else if (writeOption) begin
            option_q <= regWdata;
        end
    end

    // Interrupt enables
    always_ff @(posedge clock) begin
        if (rst) begin
            intCtl_q[7:3] <= csoir_pkg::IC_RESET[7:3];
        end else if (writeIntCtl) begin
            intCtl_q[7:3] <= regWdata[7:3];
        end
    end

    // Core interrupt flags: event wins over software clear
    always_ff @(posedge clock) begin
        if (rst) begin
            intCtl_q[2:0] <= csoir_pkg::IC_RESET[2:0];
        end else begin
            if (timerZeroOverflow) begin
                intCtl_q[csoir_pkg::IC_T0_FLAG] <= 1'b1;
            end else if (writeIntCtl) begin
                intCtl_q[csoir_pkg::IC_T0_FLAG] <=
                    regWdata[csoir_pkg::IC_T0_FLAG];
            end
            if (extEdge) begin
                intCtl_q[csoir_pkg::IC_EXT_FLAG] <= 1'b1;
            end else if (writeIntCtl) begin
                intCtl_q[csoir_pkg::IC_EXT_FLAG] <=
                    regWdata[csoir_pkg::IC_EXT_FLAG];
            end
            if (portMismatch) begin
                intCtl_q[csoir_pkg::IC_PORT_FLAG] <= 1'b1;
            end else if (writeIntCtl) begin
                intCtl_q[csoir_pkg::IC_PORT_FLAG] <=
                    regWdata[csoir_pkg::IC_PORT_FLAG];
            end
        end
    end

    // Peripheral enables, unimplemented bits held at zero
    always_ff @(posedge clock) begin
        if (rst) begin
            perEn_q <= csoir_pkg::PIE_RESET;
        end else if (writePerEn) begin
            perEn_q <= regWdata & csoir_pkg::PERIPH_IMPL_MASK;
        end
    end

    // Read data, registered
    always_ff @(posedge clock) begin
        if (rst) begin
            regRdata_q <= 8'h00;
        end else if (hits(regAddr, csoir_pkg::ADDR_ALU_FLAGS_BANK_SELECT,
                          csoir_pkg::ADDR_ANY_BANK_MASK)) begin
            regRdata_q <= status_q;
        end else if (hits(regAddr, csoir_pkg::ADDR_INTERRUPT_CONTROL_CORE,
                          csoir_pkg::ADDR_ANY_BANK_MASK)) begin
            regRdata_q <= intCtl_q;
        end else if (hits(regAddr, csoir_pkg::ADDR_TIMER_PRESCALER_CONFIG,
                          csoir_pkg::ADDR_OPTION_BANK_MASK)) begin
            regRdata_q <= option_q;
        end else if (regAddr == csoir_pkg::ADDR_PERIPHERAL_IRQ_ENABLE) begin
            regRdata_q <= perEn_q;
        end else begin
            regRdata_q <= 8'h00;   // Not held here
        end
    end

    // Divide ratios from the shared prescaler field
    always_ff @(posedge clock) begin
        if (rst) begin
            dividers_q[0] <= 8'h00;
            dividers_q[1] <= 8'h00;
        end else begin
            dividers_q[0] <= pow2m1({1'b0, option_q[2:0]} + 4'h1);
            dividers_q[1] <= pow2m1({1'b0, option_q[2:0]});
        end
    end

    // Interrupt request combining
    always_comb begin
        irq_d = intCtl_q[csoir_pkg::IC_GLOBAL_EN] & (
            (intCtl_q[csoir_pkg::IC_T0_EN] &
             intCtl_q[csoir_pkg::IC_T0_FLAG]) |
            (intCtl_q[csoir_pkg::IC_EXT_EN] &
             intCtl_q[csoir_pkg::IC_EXT_FLAG]) |
            (intCtl_q[csoir_pkg::IC_PORT_EN] &
             intCtl_q[csoir_pkg::IC_PORT_FLAG]) |
            (intCtl_q[csoir_pkg::IC_PERIPH_EN] &
             |(perEn_q & peripheralIrqFlags &
               csoir_pkg::PERIPH_IMPL_MASK)));
    end

    // Request register
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Outputs from flip-flops; timerPrescaled through an inverter
    assign regRdata          = regRdata_q;
    assign indirectBankSel   = status_q[csoir_pkg::ST_INDIRECT_BANK];
    assign directBankSel     = status_q[6:5];
    assign pullupDisable     = option_q[csoir_pkg::OPT_PULLUP_DIS];
    assign timer0SourceSel   = option_q[csoir_pkg::OPT_T0_SOURCE];
    assign timer0EdgeSel     = option_q[csoir_pkg::OPT_T0_EDGE];
    assign timerPrescaled    = ~option_q[csoir_pkg::OPT_PSC_OWNER];
    assign watchdogPrescaled = option_q[csoir_pkg::OPT_PSC_OWNER];
    assign timerDivMinus1    = dividers_q[0];
    assign watchdogDivMinus1 = dividers_q[1];
    assign irqRequest        = irq_q;
endmodule : csoir_core_regs

/* verif/csoir_core_regs_chk.sv */
// Checker: field, flag and request timing at the core register group ports
`timescale 1ns/1ns
module csoir_core_regs_chk #(
    parameter int PORT_WIDTH = 4    // Watched upper port B pins
) (
    // Clock and reset
    input wire logic clock, rst,
    // Register access
    input wire logic [8:0] regAddr,
    input wire logic       regWrite,
    input wire logic [7:0] regWdata, regRdata,
    // ALU flag update
    input wire logic nullUpdate, halfUpdate, carryUpdate,
    input wire csoir_pkg::csoir_carry_src_type carrySrc,
    input wire logic [7:0] aluResult, rotSource,
    input wire logic nibbleCarry, msbCarry,
    // Core events
    input wire logic clearWatchdogInstr, sleepInstr, watchdogTimeout,
    input wire logic timerZeroOverflow, extIrqPin, portBRead,
    input wire logic [PORT_WIDTH-1:0] upperPortBPins,
    input wire logic [7:0] peripheralIrqFlags,
    // Configuration and request
    input wire logic       indirectBankSel,
    input wire logic [1:0] directBankSel,
    input wire logic pullupDisable, timer0SourceSel, timer0EdgeSel,
    input wire logic timerPrescaled, watchdogPrescaled, irqRequest,
    input wire logic [7:0] timerDivMinus1, watchdogDivMinus1
);
    // Decoded accesses and expected carry
    logic stAcc, optWr, icWr, expCarry;
    assign stAcc = regAddr[6:0] == 7'h03;
    assign optWr = regWrite && regAddr[7:0] == 8'h81;
    assign icWr  = regWrite && regAddr[6:0] == 7'h0B;
    // Carry source follows the selected shift direction
    always_comb begin
        case (carrySrc)
            csoir_pkg::CSOIR_CARRY_ROT_LEFT:  expCarry = rotSource[7];
            csoir_pkg::CSOIR_CARRY_ROT_RIGHT: expCarry = rotSource[0];
            default:                          expCarry = msbCarry;
        endcase
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_owner; !$past(rst) |-> timerPrescaled != watchdogPrescaled;
    endproperty
    a_owner: assert property (p_owner)
        else $error("prescaler owner outputs agree");
    property p_ratio; logic [2:0] n;
        (optWr, n = regWdata[2:0]) ##1 !optWr |-> ##1
        watchdogDivMinus1 == (8'h01 << n) - 8'h01 &&
        timerDivMinus1 == (8'h02 << n) - 8'h01;
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("divider does not follow ratio field");
    property p_optbits; logic [7:0] d; (optWr, d = regWdata) |=>
        {pullupDisable, timer0SourceSel, timer0EdgeSel, watchdogPrescaled}
        == {d[7], d[5], d[4], d[3]};
    endproperty
    a_optbits: assert property (p_optbits)
        else $error("option outputs do not follow write");
    property p_bank; logic [2:0] b; (regWrite && stAcc, b = regWdata[7:5])
        |=> {indirectBankSel, directBankSel} == b;
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank selects do not follow status write");
    property p_sleep;
        sleepInstr ##1 (stAcc && !regWrite) |=> regRdata[4:3] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep did not set expiry and clear sleep flag");
    property p_tout; watchdogTimeout && !sleepInstr && !clearWatchdogInstr
        ##1 stAcc |=> !regRdata[4];
    endproperty
    a_tout: assert property (p_tout)
        else $error("timeout left expiry flag set");
    property p_t0flag; timerZeroOverflow ##1
        (regAddr[6:0] == 7'h0B && !regWrite) |=> regRdata[2];
    endproperty
    a_t0flag: assert property (p_t0flag)
        else $error("timer overflow flag not set");
    property p_null; logic z;
        (nullUpdate && regWrite && stAcc, z = (aluResult == 8'h00))
        ##1 (stAcc && !regWrite && !nullUpdate) |=> regRdata[2] == z;
    endproperty
    a_null: assert property (p_null)
        else $error("zero flag wrong after update");
    property p_carry; logic c; (carryUpdate, c = expCarry)
        ##1 (stAcc && !regWrite && !carryUpdate) |=> regRdata[0] == c;
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry flag wrong after update");
    property p_pie; regAddr == 9'h08C |=>
        (regRdata & ~csoir_pkg::PERIPH_IMPL_MASK) == 8'h00;
    endproperty
    a_pie: assert property (p_pie)
        else $error("unimplemented enable bits read nonzero");
    property p_irqoff;
        icWr && regWdata[7:6] == 2'b00 ##1 !icWr |=> !irqRequest;
    endproperty
    a_irqoff: assert property (p_irqoff)
        else $error("request with global enable clear");
    // Main scenarios
    c_sleep: cover property (sleepInstr);
    c_irq: cover property ($rose(irqRequest));
    c_opt: cover property (optWr);
endmodule : csoir_core_regs_chk

bind csoir_core_regs csoir_core_regs_chk #(.PORT_WIDTH(PORT_WIDTH)) u_chk (.*);

/* verif/csoir_core_regs_test.sv */
// Testbench: register access, flag logic and request of the core group
`timescale 1ns/1ns
module csoir_core_regs_test;
    // Design inputs
    logic clock = 1'b0, rst = 1'b1, regWrite = 1'b0;
    logic [8:0] regAddr = 9'h000;
    logic [7:0] regWdata = 8'h00, aluResult = 8'h00, rotSource = 8'h00;
    logic [7:0] peripheralIrqFlags = 8'h00, d;
    logic nullUpdate = 1'b0, halfUpdate = 1'b0, carryUpdate = 1'b0;
    logic nibbleCarry = 1'b0, msbCarry = 1'b0, portBRead = 1'b0;
    logic clearWatchdogInstr = 1'b0, sleepInstr = 1'b0, extIrqPin = 1'b0;
    logic watchdogTimeout = 1'b0, timerZeroOverflow = 1'b0;
    logic [3:0] upperPortBPins = 4'h0;
    csoir_pkg::csoir_carry_src_type carrySrc = csoir_pkg::CSOIR_CARRY_NONE;
    // Design outputs
    logic [7:0] regRdata, timerDivMinus1, watchdogDivMinus1;
    logic [1:0] directBankSel;
    logic indirectBankSel, pullupDisable, timer0SourceSel, timer0EdgeSel;
    logic timerPrescaled, watchdogPrescaled, irqRequest;
    // Counters
    int n_errors = 0;
    int comparisons = 0;
    // Table rows: address, write data, expected readback
    typedef struct { logic [8:0] a; logic [7:0] w, e; } csoir_row_type;
    csoir_row_type rows [8] = '{
        '{9'h003, 8'hA5, 8'hBD}, '{9'h083, 8'h00, 8'h18},
        '{9'h081, 8'h5A, 8'h5A}, '{9'h181, 8'hC3, 8'hC3},
        '{9'h08C, 8'hFF, 8'h4F}, '{9'h020, 8'h77, 8'h00},
        '{9'h10B, 8'h78, 8'h78}, '{9'h18B, 8'h00, 8'h00}};

    // Clock
    always #20 clock = ~clock;

    // Every port joins the bench signal of the same name
    csoir_core_regs uut (.*);

    // Wait edges, then step just past the last one
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One register write
    task automatic wr(input logic [8:0] a, input logic [7:0] w);
        regAddr = a;
        regWdata = w;
        regWrite = 1'b1;
        tick();
        regWrite = 1'b0;
    endtask : wr
    // Read one register and compare
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        regAddr = a;
        tick();
        chk(regRdata, e);
    endtask : rd
    // One-cycle event pulse
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask : pulse
    // Flag update racing a status write, then readback
    task automatic aluw(input logic [4:0] u, input logic [7:0] r, rs, w, e,
                        input csoir_pkg::csoir_carry_src_type s);
        {nullUpdate, halfUpdate, carryUpdate, nibbleCarry, msbCarry} = u;
        aluResult = r;
        rotSource = rs;
        carrySrc = s;
        wr(9'h003, w);
        {nullUpdate, halfUpdate, carryUpdate} = 3'b000;
        rd(9'h003, e);
    endtask : aluw
    // Verdict and end of run
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // Watchdog against a hang
    initial begin
        tick(3000);
        n_errors++;
        summarize();
    end

    // Main sequence
    initial begin
        tick(16);
        rst = 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        $display("table test done");
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        chk({pullupDisable, timer0SourceSel, timer0EdgeSel,
             watchdogPrescaled, timerPrescaled}, 16'h001E);
        chk({timerDivMinus1, watchdogDivMinus1}, 16'hFF7F);
        rd(9'h081, 8'hFF);
        rd(9'h00B, 8'h00);
        rd(9'h08C, 8'h00);
        rd(9'h003, 8'h18);
        $display("reset test done");
        for (int n = 0; n < 8; n++) begin
            d = {n[0], n[1], n[2], ~n[0], n[1], n[2:0]};
            wr(9'h081, d);
            tick(2);
            chk({pullupDisable, timer0SourceSel, timer0EdgeSel,
                 watchdogPrescaled, timerPrescaled},
                {d[7], d[5:3], ~d[3]});
            chk({timerDivMinus1, watchdogDivMinus1},
                {8'((2 << n) - 1), 8'((1 << n) - 1)});
        end
        $display("prescaler test done");
        aluw(5'b11111, 8'h00, 8'h00, 8'h00, 8'h1F,
             csoir_pkg::CSOIR_CARRY_ARITH);
        aluw(5'b10100, 8'h01, 8'h80, 8'hFF, 8'hFB,
             csoir_pkg::CSOIR_CARRY_ROT_LEFT);
        chk({indirectBankSel, directBankSel}, 16'h0007);
        aluw(5'b01110, 8'h00, 8'h00, 8'h44, 8'h5E,
             csoir_pkg::CSOIR_CARRY_ARITH);
        chk(directBankSel, 16'h0002);
        aluw(5'b00100, 8'h00, 8'h01, 8'h00, 8'h19,
             csoir_pkg::CSOIR_CARRY_ROT_RIGHT);
        pulse(watchdogTimeout);
        rd(9'h003, 8'h09);
        pulse(sleepInstr);
        rd(9'h003, 8'h11);
        pulse(clearWatchdogInstr);
        rd(9'h003, 8'h19);
        $display("status test done");
        wr(9'h00B, 8'h00);
        pulse(timerZeroOverflow);
        tick();
        chk(irqRequest, 16'h0000);
        rd(9'h00B, 8'h04);
        wr(9'h00B, 8'hA4);
        tick();
        chk(irqRequest, 16'h0001);
        wr(9'h00B, 8'h24);
        tick();
        chk(irqRequest, 16'h0000);
        wr(9'h00B, 8'h00);
        wr(9'h081, 8'h00);
        extIrqPin = 1'b1;
        tick(3);
        rd(9'h00B, 8'h00);
        extIrqPin = 1'b0;
        tick(3);
        rd(9'h00B, 8'h02);
        wr(9'h081, 8'h40);
        wr(9'h00B, 8'h00);
        extIrqPin = 1'b1;
        tick(3);
        rd(9'h00B, 8'h02);
        $display("core interrupt test done");
        upperPortBPins = 4'h8;
        tick(3);
        wr(9'h00B, 8'h00);
        rd(9'h00B, 8'h01);
        pulse(portBRead);
        tick(2);
        wr(9'h00B, 8'h00);
        rd(9'h00B, 8'h00);
        peripheralIrqFlags = 8'h41;
        wr(9'h08C, 8'h02);
        wr(9'h00B, 8'hC0);
        tick();
        chk(irqRequest, 16'h0000);
        wr(9'h08C, 8'h40);
        tick();
        chk(irqRequest, 16'h0001);
        wr(9'h00B, 8'h80);
        tick();
        chk(irqRequest, 16'h0000);
        $display("port and peripheral test done");
        summarize();
    end
endmodule : csoir_core_regs_test
